// ---- verilog/lsd_led_sink.sv ----
// led sink driver: serial chain, display latch, diagnostics and error modes
// What this block does
// - in normal mode each rising serial clock shifts serial_in into the shift register
// - in error mode each rising serial clock steps to the next error mode
// - output_enable_n low enables all sinks, high disables them, in any mode
// - normal mode serial_out shows a bit 8.5 serial clocks after capture
// - global error mode drives serial_out 0 on error, 1 when clean
// - a data register separate from the shift register holds the shown pattern
// - detect overtemp, open and short; latch global fault on load; read back details
// - low-current diagnostic mode runs fault tests with reduced drive
// - sixteen channels, each a sink or a sense input in diagnostics
`include "lsd_defs.svh"
module lsd_led_sink #(
	parameter int CHANNELS = `LSD_CHANNELS
) (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic SERIAL_IN,
	input wire logic SERIAL_CLK,
	input wire logic LOAD_STROBE,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic ERROR_MODE_SEL,
	input wire logic OVER_TEMP,
	input wire logic [CHANNELS-1:0] OPEN_DETECT,
	input wire logic [CHANNELS-1:0] SHORT_DETECT,
	output logic SERIAL_OUT,
	output logic LOW_CURRENT,
	output logic [CHANNELS-1:0] SINK_OUTPUTS
);
	logic sclk_q_ff;
	logic load_q_ff;
	lsd_pkg::lsd_mode_type mode_ff;
	lsd_pkg::lsd_mode_type nxt_mode;
	logic [CHANNELS-1:0] shift_ff;
	logic [CHANNELS-1:0] nxt_shift;
	logic [CHANNELS-1:0] data_ff;
	logic [CHANNELS-1:0] nxt_data;
	logic [CHANNELS-1:0] sink_ff;
	logic global_fault_ff;
	logic sout_ff;
	logic nxt_sout;
	logic low_cur_ff;

	// pins are synchronous to SYS_CLK, so edges come from one stored copy
	wire sclk_rise = SERIAL_CLK & ~sclk_q_ff;
	wire sclk_fall = ~SERIAL_CLK & sclk_q_ff;
	wire load_rise = LOAD_STROBE & ~load_q_ff;
	wire is_normal = (mode_ff == lsd_pkg::MODE_NORMAL);
	wire is_global = (mode_ff == lsd_pkg::MODE_GLOBAL);
	wire is_open = (mode_ff == lsd_pkg::MODE_OPEN);
	wire is_short = (mode_ff == lsd_pkg::MODE_SHORT);
	wire is_temp = (mode_ff == lsd_pkg::MODE_TEMP);
	wire is_lowcur = (mode_ff == lsd_pkg::MODE_LOWCUR);
	wire any_fault = OVER_TEMP | (|OPEN_DETECT) | (|SHORT_DETECT);
	wire test_load = load_rise & (is_open | is_short | is_temp | is_lowcur);
	// low-current pass tests open and short together at reduced drive
	wire [CHANNELS-1:0] test_result = is_open ? OPEN_DETECT :
		is_short ? SHORT_DETECT :
		is_temp ? {CHANNELS{OVER_TEMP}} :
		(OPEN_DETECT | SHORT_DETECT);
	wire [CHANNELS-1:0] shifted = {shift_ff[CHANNELS-2:0], SERIAL_IN};

	// mode sequence; leaving error mode always returns to normal shifting
	always_comb begin
		nxt_mode = mode_ff;
		if (!ERROR_MODE_SEL) begin
			nxt_mode = lsd_pkg::MODE_NORMAL;
		end else if (is_normal) begin
			nxt_mode = lsd_pkg::MODE_GLOBAL;
		end else if (sclk_rise) begin
			unique case (mode_ff)
				lsd_pkg::MODE_GLOBAL: nxt_mode = lsd_pkg::MODE_OPEN;
				lsd_pkg::MODE_OPEN: nxt_mode = lsd_pkg::MODE_SHORT;
				lsd_pkg::MODE_SHORT: nxt_mode = lsd_pkg::MODE_TEMP;
				lsd_pkg::MODE_TEMP: nxt_mode = lsd_pkg::MODE_LOWCUR;
				lsd_pkg::MODE_LOWCUR: nxt_mode = lsd_pkg::MODE_GLOBAL;
				default: nxt_mode = lsd_pkg::MODE_NORMAL;
			endcase
		end
	end

	// test results land in the shift register so normal shifting reads them back
	assign nxt_shift = test_load ? test_result :
		(sclk_rise & is_normal) ? shifted : shift_ff;
	assign nxt_data = (load_rise & is_normal) ? shift_ff : data_ff;
	// output moves on the falling edge: tap 8 plus half a clock gives 8.5
	assign nxt_sout = is_global ? ~global_fault_ff :
		(sclk_fall & is_normal) ? shift_ff[`LSD_OUT_TAP] : sout_ff;

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sclk_q_ff <= 1'b0;
			load_q_ff <= 1'b0;
			mode_ff <= lsd_pkg::MODE_NORMAL;
		end else begin
			sclk_q_ff <= SERIAL_CLK;
			load_q_ff <= LOAD_STROBE;
			mode_ff <= nxt_mode;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			shift_ff <= CHANNELS'(`LSD_SHIFT_RESET);
			data_ff <= CHANNELS'(`LSD_DATA_RESET);
			global_fault_ff <= 1'b0;
		end else begin
			shift_ff <= nxt_shift;
			data_ff <= nxt_data;
			if (load_rise) begin
				global_fault_ff <= any_fault;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sink_ff <= '0;
			sout_ff <= 1'b1;
			low_cur_ff <= 1'b0;
		end else begin
			sink_ff <= OUTPUT_ENABLE_N ? '0 : data_ff;
			sout_ff <= nxt_sout;
			low_cur_ff <= is_lowcur;
		end
	end

	assign SINK_OUTPUTS = sink_ff;
	assign SERIAL_OUT = sout_ff;
	assign LOW_CURRENT = low_cur_ff;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RSTN);

	shift_step_a: assert property (
		sclk_rise && is_normal && !test_load |=> shift_ff == $past(shifted))
		else $error("shift register did not take serial_in");
	mode_step_a: assert property (
		ERROR_MODE_SEL && is_global && sclk_rise |=> mode_ff == lsd_pkg::MODE_OPEN)
		else $error("error mode did not advance");
	err_hold_a: assert property (
		!is_normal && !test_load |=> $stable(shift_ff))
		else $error("shift register moved in error mode");
	oe_gate_a: assert property (
		OUTPUT_ENABLE_N |=> SINK_OUTPUTS == '0)
		else $error("sinks on while disabled");
	sink_follow_a: assert property (
		!OUTPUT_ENABLE_N |=> SINK_OUTPUTS == $past(data_ff))
		else $error("sinks do not follow data register");
	tap_delay_a: assert property (
		is_normal && sclk_fall |=> SERIAL_OUT == $past(shift_ff[`LSD_OUT_TAP]))
		else $error("serial_out tap wrong");
	global_out_a: assert property (
		is_global |=> SERIAL_OUT == !$past(global_fault_ff))
		else $error("global error report wrong");
	data_hold_a: assert property (
		!load_rise |=> $stable(data_ff))
		else $error("data register changed without load");
	load_copy_a: assert property (
		load_rise && is_normal |=> data_ff == $past(shift_ff))
		else $error("load did not copy shift register");
	fault_latch_a: assert property (
		load_rise |=> global_fault_ff == $past(any_fault))
		else $error("global fault not latched on load");
	low_drive_a: assert property (
		is_lowcur |=> LOW_CURRENT)
		else $error("low current not signalled");
	low_drive_off_a: assert property (
		!is_lowcur |=> !LOW_CURRENT)
		else $error("low current left on");
	shift_idle_a: assert property (
		is_normal && !sclk_rise |=> $stable(shift_ff))
		else $error("shift register moved without serial clock");
	tap_hold_a: assert property (
		is_normal && !sclk_fall |=> $stable(SERIAL_OUT))
		else $error("serial_out moved without serial fall");
	data_keep_a: assert property (
		load_rise && !is_normal |=> $stable(data_ff))
		else $error("data register changed by a test load");
	fault_hold_a: assert property (
		!load_rise |=> $stable(global_fault_ff))
		else $error("global fault changed without load");

	// each step checked on its own so a skipped mode shows where it went wrong
	mode_enter_a: assert property (
		ERROR_MODE_SEL && is_normal |=> is_global)
		else $error("error mode not entered");
	mode_open_a: assert property (
		ERROR_MODE_SEL && is_open && sclk_rise |=> mode_ff == lsd_pkg::MODE_SHORT)
		else $error("open mode did not advance");
	mode_short_a: assert property (
		ERROR_MODE_SEL && is_short && sclk_rise |=> mode_ff == lsd_pkg::MODE_TEMP)
		else $error("short mode did not advance");
	mode_temp_a: assert property (
		ERROR_MODE_SEL && is_temp && sclk_rise |=> mode_ff == lsd_pkg::MODE_LOWCUR)
		else $error("temperature mode did not advance");
	mode_wrap_a: assert property (
		ERROR_MODE_SEL && is_lowcur && sclk_rise |=> is_global)
		else $error("low current mode did not wrap");
	mode_exit_a: assert property (
		!ERROR_MODE_SEL |=> is_normal)
		else $error("error mode not left");

	// expected captures come from the pins, not from the result mux
	open_fill_a: assert property (
		test_load && is_open |=> shift_ff == $past(OPEN_DETECT))
		else $error("open results not captured");
	short_fill_a: assert property (
		test_load && is_short |=> shift_ff == $past(SHORT_DETECT))
		else $error("short results not captured");
	temp_fill_a: assert property (
		test_load && is_temp |=> shift_ff == {CHANNELS{$past(OVER_TEMP)}})
		else $error("temperature result not captured");
	both_fill_a: assert property (
		test_load && is_lowcur |=> shift_ff == ($past(OPEN_DETECT) | $past(SHORT_DETECT)))
		else $error("low current results not captured");

	load_normal_c: cover property (load_rise && is_normal);
	global_err_c: cover property (is_global && global_fault_ff);
	mode_wrap_c: cover property (is_lowcur && sclk_rise && ERROR_MODE_SEL ##1 is_global);
	test_read_c: cover property (test_load && |test_result);
	temp_cap_c: cover property (test_load && is_temp && OVER_TEMP);
endmodule : lsd_led_sink

// ---- verilog/lsd_defs.svh ----
// constants for the led sink shift driver
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
`define LSD_CHANNELS 16
`define LSD_OUT_TAP 8
`define LSD_DATA_RESET 16'h0000
`define LSD_SHIFT_RESET 16'h0000
`define LSD_MODE_NORMAL 6'h01
`define LSD_MODE_GLOBAL 6'h02
`define LSD_MODE_OPEN 6'h04
`define LSD_MODE_SHORT 6'h08
`define LSD_MODE_TEMP 6'h10
`define LSD_MODE_LOWCUR 6'h20
`endif

// ---- verilog/lsd_pkg.sv ----
// types for the led sink shift driver
`include "lsd_defs.svh"
package lsd_pkg;
	typedef enum logic [5:0] {
		MODE_NORMAL = `LSD_MODE_NORMAL,
		MODE_GLOBAL = `LSD_MODE_GLOBAL,
		MODE_OPEN = `LSD_MODE_OPEN,
		MODE_SHORT = `LSD_MODE_SHORT,
		MODE_TEMP = `LSD_MODE_TEMP,
		MODE_LOWCUR = `LSD_MODE_LOWCUR
	} lsd_mode_type;
endpackage : lsd_pkg

// ---- test/lsd_ctl_model.sv ----
// display controller model driving the serial chain
module lsd_ctl_model (
	input wire logic clk,
	output logic serial_in,
	output logic serial_clk,
	output logic load_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		serial_in = 1'b0;
		serial_clk = 1'b0;
		load_strobe = 1'b0;
	end
	// each clock level held two cycles, clock stands low between frames
	task automatic pulse(input logic b);
		@(posedge clk);
		serial_in <= b;
		serial_clk <= 1'b1;
		repeat (2) @(posedge clk);
		serial_clk <= 1'b0;
		@(posedge clk);
	endtask : pulse
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			pulse(w[i]);
		end
		serial_in <= ~w[0];
	endtask : send
	task automatic load();
		@(posedge clk);
		load_strobe <= 1'b1;
		@(posedge clk);
		load_strobe <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : load
endmodule : lsd_ctl_model

// ---- test/tb.sv ----
// self-checking bench for the led sink driver
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic output_enable_n = 1'b1;
	logic sel = 1'b0;
	logic temp = 1'b0;
	logic [15:0] open_d = 16'h0000;
	logic [15:0] short_d = 16'h0000;
	logic [15:0] sinks;
	logic sout, lowc, ser_in, sclk, load_pin;
	int bad_count = 0;
	int n_tests = 0;
	always #4 clk = ~clk;
	lsd_ctl_model ctl (.clk(clk), .serial_in(ser_in), .serial_clk(sclk), .load_strobe(load_pin));
	lsd_led_sink dut (.SYS_CLK(clk), .RSTN(rstn), .SERIAL_IN(ser_in), .SERIAL_CLK(sclk),
		.LOAD_STROBE(load_pin), .OUTPUT_ENABLE_N(output_enable_n), .ERROR_MODE_SEL(sel),
		.OVER_TEMP(temp),
		.OPEN_DETECT(open_d), .SHORT_DETECT(short_d), .SERIAL_OUT(sout),
		.LOW_CURRENT(lowc), .SINK_OUTPUTS(sinks));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic t_data();
		ctl.send(16'ha5c3);
		tick(1);
		`CHK("tap", 1'b1, sout)
		ctl.load();
		@(posedge clk) output_enable_n <= 1'b0;
		tick(2);
		`CHK("sinks", 16'ha5c3, sinks)
		ctl.send(16'h5a3c);
		tick(1);
		`CHK("tap", 1'b0, sout)
		`CHK("held", 16'ha5c3, sinks)
		@(posedge clk) output_enable_n <= 1'b1;
		tick(2);
		`CHK("off", 16'h0000, sinks)
		@(posedge clk) output_enable_n <= 1'b0;
		$display("t_data done");
	endtask : t_data
	task automatic t_diag();
		@(posedge clk) begin
			open_d <= 16'h0100;
			sel <= 1'b1;
		end
		tick(2);
		ctl.load();
		tick(1);
		`CHK("fault", 1'b0, sout)
		ctl.pulse(1'b0);
		ctl.load();
		@(posedge clk) sel <= 1'b0;
		tick(2);
		ctl.load();
		tick(1);
		`CHK("readback", 16'h0100, sinks)
		@(posedge clk) begin
			sel <= 1'b1;
			open_d <= 16'h0000;
		end
		tick(2);
		repeat (4) ctl.pulse(1'b0);
		tick(1);
		`CHK("lowcur", 1'b1, lowc)
		ctl.pulse(1'b0);
		ctl.load();
		tick(1);
		`CHK("clean", 1'b1, sout)
		@(posedge clk) sel <= 1'b0;
		tick(2);
		$display("t_diag done");
	endtask : t_diag
	// enter error mode, step to a test mode, capture, leave and load the result
	task automatic capture(input int steps);
		@(posedge clk) sel <= 1'b1;
		tick(2);
		repeat (steps) ctl.pulse(1'b0);
		ctl.load();
		@(posedge clk) sel <= 1'b0;
		tick(2);
		ctl.load();
		tick(1);
	endtask : capture
	task automatic t_tests();
		@(posedge clk) short_d <= 16'h8001;
		capture(2);
		`CHK("short", 16'h8001, sinks)
		@(posedge clk) temp <= 1'b1;
		capture(3);
		`CHK("temp", 16'hffff, sinks)
		@(posedge clk) begin
			temp <= 1'b0;
			open_d <= 16'h0010;
		end
		@(posedge clk) sel <= 1'b1;
		tick(2);
		repeat (4) ctl.pulse(1'b0);
		ctl.load();
		tick(1);
		`CHK("lowcur on", 1'b1, lowc)
		@(posedge clk) sel <= 1'b0;
		tick(2);
		`CHK("lowcur off", 1'b0, lowc)
		ctl.load();
		tick(1);
		`CHK("both", 16'h8011, sinks)
		@(posedge clk) begin
			open_d <= 16'h0000;
			short_d <= 16'h0000;
		end
		$display("t_tests done");
	endtask : t_tests
	task automatic t_reset();
		@(posedge clk) sel <= 1'b1;
		tick(2);
		repeat (4) ctl.pulse(1'b0);
		tick(1);
		`CHK("pre reset", 1'b1, lowc)
		@(posedge clk) begin
			rstn <= 1'b0;
			sel <= 1'b0;
		end
		tick(1);
		`CHK("reset sinks", 16'h0000, sinks)
		`CHK("reset out", 1'b1, sout)
		`CHK("reset low", 1'b0, lowc)
		@(posedge clk) rstn <= 1'b1;
		tick(2);
		`CHK("reset data", 16'h0000, sinks)
		ctl.send(16'h1234);
		tick(1);
		`CHK("reset tap", 1'b0, sout)
		ctl.load();
		tick(1);
		`CHK("after reset", 16'h1234, sinks)
		$display("t_reset done");
	endtask : t_reset
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_data();
		t_diag();
		t_tests();
		t_reset();
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		stop_test();
	end
endmodule : tb
